// [aprs_consts.vh]
// Constants for the axis position, ramp and stop logic
// Overview of operation
// - Zero at transmitter, rising away from it
// - Origin shift added modulo 65536
// - Count sense 65535 inverts, 0 keeps normal
// - Inverted count is 65536 minus raw count, before the shift
// - Target behind near bound goes to near
// - Target beyond far bound goes to far
// - Load-parameters command adopts staged parameters
// - Default ramps are lengths in position units
// - Mode bit 16 selects rate ramps
// - Rate distance is speed squared over 2000*rate
// - Sample position every two milliseconds
// - Obstruction sets status bit 10
// - Masks pick ramped halt or immediate stop
// - Detection only at 1 inch/second or faster
// - Obstruction flagged 10 ms after onset
// - Save-null command stores current null
// - Restore-null command reloads stored null
`ifndef APRS_CONSTS_VH
`define APRS_CONSTS_VH
`define APRS_CLK_MHZ 125
`define APRS_SAMPLE_US 2000
`define APRS_DETECT_US 10000
`define APRS_SAMPLE_CYC (`APRS_SAMPLE_US * `APRS_CLK_MHZ)
`define APRS_DETECT_SAMPLES (`APRS_DETECT_US / `APRS_SAMPLE_US)
`define APRS_MIN_SPEED 16'h03e8
`define APRS_MIN_STEP 16'h0002
`define APRS_RAMP_K 16'h07d0
`define APRS_INVERT_SENSE 16'hffff
`define APRS_MODE_RATE_BIT 16
`define APRS_STAT_OBSTRUCT_BIT 10
`define APRS_CMD_LOAD 8'h50
`define APRS_CMD_SAVE 8'h53
`define APRS_CMD_RESTORE 8'h52
`define APRS_NULL_RESET 16'h0000
`endif

// [aprs_ramp_calc.v]
// Ramp distance calculator: distance or rate interpretation
`timescale 1ns/1ns
`include "aprs_consts.vh"
module aprs_ramp_calc #(
    parameter W = 16
) (
    input wire sys_clk, // System clock
    input wire rst, // Async reset, active high
    input wire rate_mode, // Ramp values are rates
    input wire [W-1:0] speed, // Commanded speed
    input wire [W-1:0] ramp_val, // Accel or decel field
    output reg [W-1:0] ramp_dist // Resulting ramp length
);
    wire [2*W-1:0] spd_sq;
    wire [2*W-1:0] denom;
    wire [2*W-1:0] quot;
    assign spd_sq = speed * speed;
    assign denom = `APRS_RAMP_K * ramp_val;
    // Zero rate would divide by zero; treat as full ramp
    assign quot = (denom == {(2*W){1'b0}}) ? {(2*W){1'b1}} : spd_sq / denom;

    ////////////////////////////////////////////////////////////////
    // Registered result, saturated to the field width
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            ramp_dist <= {W{1'b0}};
        else if (rate_mode)
            ramp_dist <= (quot[2*W-1:W] != {W{1'b0}}) ? {W{1'b1}} : quot[W-1:0];
        else
            ramp_dist <= ramp_val;
    end
endmodule // aprs_ramp_calc

// [aprs_axis.v]
// Per-axis position conversion, clamp, ramps, obstruction and null store
`timescale 1ns/1ns
`include "aprs_consts.vh"
module aprs_axis #(
    parameter SAMPLE_CYC = `APRS_SAMPLE_CYC,
    parameter DETECT_SAMPLES = `APRS_DETECT_SAMPLES
) (
    input wire sys_clk, // System clock
    input wire rst, // Async reset, active high
    input wire [15:0] raw_pos, // Raw transducer count
    input wire [15:0] init_offset, // Staged origin shift
    input wire [15:0] init_direction, // Staged count sense
    input wire [15:0] init_extend_lim, // Staged far bound
    input wire [15:0] init_retract_lim, // Staged near bound
    input wire [15:0] init_transmitter, // Staged transmitter position
    input wire [31:0] mode_word, // Mode word
    input wire [15:0] accel_val, // Accel field
    input wire [15:0] decel_val, // Decel field
    input wire [15:0] speed, // Commanded speed
    input wire [15:0] req_pos, // Requested position
    input wire [7:0] cmd_letter, // Command letter
    input wire cmd_valid, // Command strobe, one cycle
    input wire axis_moving, // Motion in progress
    input wire halt_mask_n, // Low enables stop on obstruction
    input wire estop_mask_n, // Low selects immediate stop
    input wire [15:0] cur_null, // Live null from servo loop
    input wire obstruct_clear, // Clears obstruction flag
    output reg [15:0] act_pos, // Converted actual position
    output reg [15:0] target_pos, // Clamped target
    output wire [15:0] accel_dist, // Accel ramp length
    output wire [15:0] decel_dist, // Decel ramp length
    output reg [15:0] status_word, // Status word
    output reg halt_req, // Ramped halt request
    output reg estop_req, // Immediate stop request
    output reg [15:0] null_out, // Active null
    output reg null_load, // Null reload pulse
    output reg params_loaded // Parameters adopted
);
    reg [15:0] offset_reg, direction_reg, ext_lim_reg, ret_lim_reg, xmit_reg;
    reg [15:0] saved_null_reg;
    reg [31:0] tick_cnt_reg;
    reg [15:0] last_pos_reg;
    reg [3:0] slow_cnt_reg;
    reg obstruct_reg;
    wire [15:0] sensed;
    wire [15:0] pos_next;
    wire tick;
    wire [15:0] step;
    wire stalled;
    wire [15:0] rel_req, rel_ret, rel_ext;

    // Command decode shared by every command letter
    function is_cmd;
        input valid;
        input [7:0] letter;
        input [7:0] code;
        begin
            is_cmd = valid && (letter == code);
        end
    endfunction

    ////////////////////////////////////////////////////////////////
    // Position conversion: sense first, then shift
    assign sensed = (direction_reg == `APRS_INVERT_SENSE) ? (16'h0000 - raw_pos) : raw_pos;
    assign pos_next = sensed + offset_reg;
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            act_pos <= 16'h0000;
        else
            act_pos <= pos_next;
    end

    ////////////////////////////////////////////////////////////////
    // Parameter adoption and null store
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            offset_reg <= 16'h0000;
            direction_reg <= 16'h0000;
            ext_lim_reg <= 16'hffff;
            ret_lim_reg <= 16'h0000;
            xmit_reg <= 16'h0000;
            params_loaded <= 1'b0;
            saved_null_reg <= `APRS_NULL_RESET;
            null_out <= `APRS_NULL_RESET;
            null_load <= 1'b0;
        end
        else
        begin
            null_load <= 1'b0;
            if (is_cmd(cmd_valid, cmd_letter, `APRS_CMD_LOAD))
            begin
                offset_reg <= init_offset;
                direction_reg <= init_direction;
                ext_lim_reg <= init_extend_lim;
                ret_lim_reg <= init_retract_lim;
                xmit_reg <= init_transmitter;
                params_loaded <= 1'b1;
            end
            if (is_cmd(cmd_valid, cmd_letter, `APRS_CMD_SAVE))
                saved_null_reg <= cur_null;
            if (is_cmd(cmd_valid, cmd_letter, `APRS_CMD_RESTORE))
            begin
                null_out <= saved_null_reg;
                null_load <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Target clamp, measured circularly from the transmitter so wrap is handled
    assign rel_req = req_pos - xmit_reg;
    assign rel_ret = ret_lim_reg - xmit_reg;
    assign rel_ext = ext_lim_reg - xmit_reg;
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            target_pos <= 16'h0000;
        else if (rel_req < rel_ret)
            target_pos <= ret_lim_reg;
        else if (rel_req > rel_ext)
            target_pos <= ext_lim_reg;
        else
            target_pos <= req_pos;
    end

    ////////////////////////////////////////////////////////////////
    // Ramp distances for both directions share one calculator form
    aprs_ramp_calc #(.W(16)) u_acc (
        .sys_clk(sys_clk),
        .rst(rst),
        .rate_mode(mode_word[`APRS_MODE_RATE_BIT]),
        .speed(speed),
        .ramp_val(accel_val),
        .ramp_dist(accel_dist)
    );
    aprs_ramp_calc #(.W(16)) u_dec (
        .sys_clk(sys_clk),
        .rst(rst),
        .rate_mode(mode_word[`APRS_MODE_RATE_BIT]),
        .speed(speed),
        .ramp_val(decel_val),
        .ramp_dist(decel_dist)
    );

    ////////////////////////////////////////////////////////////////
    // Two millisecond sample tick
    assign tick = (tick_cnt_reg == SAMPLE_CYC - 1);
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            tick_cnt_reg <= 32'h00000000;
        else if (tick)
            tick_cnt_reg <= 32'h00000000;
        else
            tick_cnt_reg <= tick_cnt_reg + 32'h00000001;
    end

    ////////////////////////////////////////////////////////////////
    // Obstruction: consecutive stalled samples while commanded fast enough
    assign step = (act_pos > last_pos_reg) ? act_pos - last_pos_reg : last_pos_reg - act_pos;
    assign stalled = axis_moving && (speed >= `APRS_MIN_SPEED) && (step < `APRS_MIN_STEP);
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            last_pos_reg <= 16'h0000;
            slow_cnt_reg <= 4'h0;
            obstruct_reg <= 1'b0;
        end
        else
        begin
            if (tick)
            begin
                last_pos_reg <= act_pos;
                if (!stalled)
                    slow_cnt_reg <= 4'h0;
                else if (slow_cnt_reg != DETECT_SAMPLES[3:0])
                    slow_cnt_reg <= slow_cnt_reg + 4'h1;
            end
            // Set wins over clear; a saturated count keeps flagging after a clear
            if (tick && stalled && slow_cnt_reg >= DETECT_SAMPLES[3:0] - 4'h1)
                obstruct_reg <= 1'b1;
            else if (obstruct_clear)
                obstruct_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Status and stop selection
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            status_word <= 16'h0000;
            halt_req <= 1'b0;
            estop_req <= 1'b0;
        end
        else
        begin
            status_word <= 16'h0000;
            status_word[`APRS_STAT_OBSTRUCT_BIT] <= obstruct_reg;
            halt_req <= obstruct_reg && !halt_mask_n && estop_mask_n;
            estop_req <= obstruct_reg && !halt_mask_n && !estop_mask_n;
        end
    end
endmodule // aprs_axis

// [aprs_axis_asserts.sv]
// Concurrent checks on the axis block ports
`timescale 1ns/1ns
module aprs_axis_asserts (
    input wire sys_clk, // System clock
    input wire rst, // Async reset
    input wire cmd_valid, // Command strobe
    input wire [7:0] cmd_letter, // Command letter
    input wire null_load, // Null reload pulse
    input wire params_loaded, // Parameters adopted
    input wire halt_mask_n, // Stop enable, low
    input wire estop_mask_n, // Immediate stop select, low
    input wire halt_req, // Ramped halt
    input wire estop_req, // Immediate stop
    input wire axis_moving, // Motion in progress
    input wire [31:0] mode_word, // Mode word
    input wire [15:0] speed, // Commanded speed
    input wire [15:0] accel_val, // Accel field
    input wire [15:0] accel_dist, // Accel ramp length
    input wire [15:0] status_word // Status word
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////
    // Command and flag events
    sequence restore_cmd;
        cmd_valid && cmd_letter == 8'h52;
    endsequence
    sequence flag_rise;
        $rose(status_word[10]);
    endsequence
    a_load_adopts: assert property (cmd_valid && cmd_letter == 8'h50 |=> params_loaded)
        else $error("load command not adopted");
    a_restore_pulse: assert property (restore_cmd |=> null_load ##1 !null_load)
        else $error("restore pulse wrong");
    a_reload_cause: assert property (null_load |-> $past(cmd_valid) && $past(cmd_letter) == 8'h52)
        else $error("null reload without restore");
    a_status_clean: assert property (status_word[15:11] == 5'h00 && status_word[9:0] == 10'h000)
        else $error("stray status bits");
    a_estop_follows: assert property (flag_rise ##0 (!halt_mask_n && !estop_mask_n) |=> estop_req)
        else $error("immediate stop missing");
    a_halt_ramped: assert property (flag_rise ##0 (!halt_mask_n && estop_mask_n) |=> halt_req && !estop_req)
        else $error("ramped halt missing");
    a_mask_blocks: assert property (halt_mask_n |=> !halt_req && !estop_req)
        else $error("stop while masked");
    // Flag may only come from fast motion; speed seen two edges before
    a_fast_only: assert property (flag_rise |-> $past(speed, 2) >= 16'h03e8 && $past(axis_moving, 2))
        else $error("flag at slow speed");
    a_dist_mode: assert property (!mode_word[16] |=> accel_dist == $past(accel_val))
        else $error("distance ramp wrong");
endmodule // aprs_axis_asserts
bind aprs_axis aprs_axis_asserts chk (.*);

// [aprs_xdcr_model.sv]
// Transducer stand-in: a rod count that moves or stalls
`timescale 1ns/1ns
module aprs_xdcr_model (
    input wire sys_clk, // System clock
    input wire rst, // Async reset
    input wire run, // Rod moving freely
    output reg [15:0] raw_pos // Rod count
);
    // One count a cycle while free; a blocked rod holds still
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            raw_pos <= 16'h2710;
        else if (run)
            raw_pos <= raw_pos + 16'h0001;
    end
endmodule // aprs_xdcr_model

// [aprs_axis_test.sv]
// Self-checking bench for the axis position block
`timescale 1ns/1ns
module aprs_axis_test;
    reg sys_clk = 1'b0, rst = 1'b1, cmd_valid = 1'b0, axis_moving = 1'b0, run = 1'b0;
    reg halt_mask_n = 1'b1, estop_mask_n = 1'b1, obstruct_clear = 1'b0;
    reg [15:0] init_offset = 16'h0000, init_direction = 16'h0000, init_transmitter = 16'h0000;
    reg [15:0] init_extend_lim = 16'h88b8, init_retract_lim = 16'h1f40, cur_null = 16'h0000;
    reg [15:0] accel_val = 16'h0000, decel_val = 16'h0000, speed = 16'h0000, req_pos = 16'h0000;
    reg [31:0] mode_word = 32'h0000_0000;
    reg [7:0] cmd_letter = 8'h00;
    wire [15:0] raw_pos, act_pos, target_pos, accel_dist, decel_dist, status_word, null_out;
    wire halt_req, estop_req, null_load, params_loaded;
    integer n_mismatch = 0, comparisons = 0, i;
    always #4 sys_clk = ~sys_clk;
    aprs_xdcr_model xdcr (.*);
    // Short sample period keeps the stall timing inside a brief run
    aprs_axis #(.SAMPLE_CYC(20), .DETECT_SAMPLES(5)) dut (.*);
    ////////////////////////////////////////////////////////////
    task chk(input [15:0] got, input [15:0] exp);
    begin
        comparisons = comparisons + 1;
        if (got !== exp)
        begin
            n_mismatch = n_mismatch + 1;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    end
    endtask
    // Strobe is one cycle; callers let an edge pass before the next
    task cmd(input [7:0] l);
    begin
        cmd_letter = l;
        cmd_valid = 1'b1;
        @(negedge sys_clk);
        cmd_valid = 1'b0;
    end
    endtask
    task load(input [15:0] o, input [15:0] d);
    begin
        init_offset = o;
        init_direction = d;
        cmd(8'h50);
        repeat (2) @(negedge sys_clk);
    end
    endtask
    // Stall at threshold speed; flag lands after five stalled samples
    task obstruct(input em, input eh, input ee);
    begin
        halt_mask_n = 1'b0;
        estop_mask_n = em;
        axis_moving = 1'b1;
        i = 0;
        while (status_word[10] !== 1'b1 && i < 200)
        begin
            @(negedge sys_clk);
            i = i + 1;
        end
        chk({15'h0000, i > 75 && i < 110}, 16'h0001);
        if (i == 200)
            print_verdict;
        chk(status_word, 16'h0400);
        @(negedge sys_clk);
        chk({14'h0000, halt_req, estop_req}, {14'h0000, eh, ee});
        axis_moving = 1'b0;
        obstruct_clear = 1'b1;
        // Let one idle sample pass so the stall count restarts
        repeat (25) @(negedge sys_clk);
        obstruct_clear = 1'b0;
        chk(status_word, 16'h0000);
    end
    endtask
    task print_verdict;
    begin
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    end
    endtask
    ////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20) @(negedge sys_clk);
        rst = 1'b0;
        load(16'h0000, 16'h0000);
        chk({15'h0000, params_loaded}, 16'h0001);
        chk(act_pos, 16'h2710);
        load(16'he0c0, 16'h0000);
        chk(act_pos, 16'h07d0);
        load(16'h0000, 16'hffff);
        chk(act_pos, 16'hd8f0);
        load(16'h88b8, 16'hffff);
        chk(act_pos, 16'h61a8);
        load(16'h0000, 16'h0000);
        $display("conversion test done");
        req_pos = 16'h0fa0;
        @(negedge sys_clk);
        chk(target_pos, 16'h1f40);
        req_pos = 16'h9c40;
        @(negedge sys_clk);
        chk(target_pos, 16'h88b8);
        $display("clamp test done");
        accel_val = 16'h07d0;
        decel_val = 16'h05dc;
        speed = 16'h07d0;
        repeat (2) @(negedge sys_clk);
        chk(accel_dist, 16'h07d0);
        chk(decel_dist, 16'h05dc);
        mode_word = 32'h0001_0000;
        accel_val = 16'h0001;
        decel_val = 16'h0004;
        repeat (2) @(negedge sys_clk);
        chk(accel_dist, 16'h07d0);
        chk(decel_dist, 16'h01f4);
        $display("ramp test done");
        // Slow stall, then fast free motion: neither may flag
        halt_mask_n = 1'b0;
        axis_moving = 1'b1;
        speed = 16'h03e7;
        repeat (150) @(negedge sys_clk);
        chk(status_word, 16'h0000);
        speed = 16'h03e8;
        run = 1'b1;
        repeat (150) @(negedge sys_clk);
        chk(status_word, 16'h0000);
        run = 1'b0;
        axis_moving = 1'b0;
        // Rod at rest for a full sample before the stall starts
        repeat (25) @(negedge sys_clk);
        obstruct(1'b0, 1'b0, 1'b1);
        obstruct(1'b1, 1'b1, 1'b0);
        $display("obstruction test done");
        cur_null = 16'h1234;
        cmd(8'h53);
        cur_null = 16'h5678;
        @(negedge sys_clk);
        cmd(8'h52);
        chk(null_out, 16'h1234);
        chk({15'h0000, null_load}, 16'h0001);
        $display("null test done");
        print_verdict;
    end
endmodule // aprs_axis_test
